// File: src/acs_top.sv
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module acs_top
    import acs_pkg::*;
(
    input  wire logic                  REF_CLK_IN,
    input  wire logic                  RESET_N_IN,
    input  wire logic [ACS_ADDR_W-1:0] S_AXI_AWADDR_IN,
    input  wire logic                  S_AXI_AWVALID_IN,
    output logic                       S_AXI_AWREADY_OUT,
    input  wire logic [31:0]           S_AXI_WDATA_IN,
    input  wire logic [3:0]            S_AXI_WSTRB_IN,
    input  wire logic                  S_AXI_WVALID_IN,
    output logic                       S_AXI_WREADY_OUT,
    output logic [1:0]                 S_AXI_BRESP_OUT,
    output logic                       S_AXI_BVALID_OUT,
    input  wire logic                  S_AXI_BREADY_IN,
    input  wire logic [ACS_ADDR_W-1:0] S_AXI_ARADDR_IN,
    input  wire logic                  S_AXI_ARVALID_IN,
    output logic                       S_AXI_ARREADY_OUT,
    output logic [31:0]                S_AXI_RDATA_OUT,
    output logic [1:0]                 S_AXI_RRESP_OUT,
    output logic                       S_AXI_RVALID_OUT,
    input  wire logic                  S_AXI_RREADY_IN,
    input  wire logic                  EXT_CONV_TRIGGER_PIN_IN,
    input  wire logic                  COMP_ABOVE_IN,
    input  wire logic                  INT_ACK_IN,
    output logic                       CONV_IRQ_OUT,
    output logic                       BUSY_OUT,
    output logic [2:0]                 ANALOG_INPUT_N_OUT,
    output logic [7:0]                 ANALOG_EN_OUT,
    output logic [7:0]                 DAC_CODE_OUT
);
    // register decode helpers
    function automatic logic hit(input logic [ACS_ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = a[7:2] == ofs[7:2];
    endfunction

    function automatic logic is_result(input logic [ACS_ADDR_W-1:0] a);
        is_result = a[7:5] == OFS_RESULT[7:5];
    endfunction

    function automatic logic mapped(input logic [ACS_ADDR_W-1:0] a);
        mapped = hit(a, OFS_CTRL) || hit(a, OFS_SWEEP) ||
                 hit(a, OFS_IRQ) || is_result(a);
    endfunction

    // last input of a sweep: 1, 3, 5 or 7
    function automatic logic [2:0] sweep_last(input logic [1:0] s);
        sweep_last = {s, 1'b1};
    endfunction

    acs_sar_if sar_if ();

    acs_sar u_sar (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RESET_N_IN),
        .sar      (sar_if.sar)
    );

    logic                  aw_held_ff, nxt_aw_held;
    logic [ACS_ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
    logic                  w_held_ff,  nxt_w_held;
    logic [31:0]           w_data_ff,  nxt_w_data;
    logic [3:0]            w_strb_ff,  nxt_w_strb;
    logic                  bvalid_ff,  nxt_bvalid;
    logic [1:0]            bresp_ff,   nxt_bresp;
    logic                  rvalid_ff,  nxt_rvalid;
    logic [31:0]           rdata_ff,   nxt_rdata;
    logic [1:0]            rresp_ff,   nxt_rresp;
    logic                  do_wr, ctrl_wr, sweep_wr, irq_wr;

    logic                  trig_s1_ff, trig_s2_ff, trig_s3_ff;
    logic                  comp_s1_ff, comp_s2_ff;
    logic                  trig_fall;

    acs_state_t            state_ff,   nxt_state;
    acs_mode_t             mode_ff,    nxt_mode;
    logic                  ext_ff,     nxt_ext;
    logic [2:0]            sel_ff,     nxt_sel;
    logic                  start_ff,   nxt_start;
    logic [1:0]            sweep_ff,   nxt_sweep;
    logic                  irq_ff,     nxt_irq;
    logic [2:0]            chan_ff,    nxt_chan;
    logic [7:0]            en_ff,      nxt_en;
    logic                  trig, finish, res_we, go, stop;
    logic                  is_sweep,   is_repeat;
    logic                  eff_ext,    eff_sweep;
    logic [2:0]            eff_sel;
    logic [7:0]            result_mem [8];

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    assign S_AXI_AWREADY_OUT = !aw_held_ff && !bvalid_ff;
    assign S_AXI_WREADY_OUT  = !w_held_ff && !bvalid_ff;
    assign S_AXI_ARREADY_OUT = !rvalid_ff;
    assign do_wr    = aw_held_ff && w_held_ff && !bvalid_ff;
    assign ctrl_wr  = do_wr && hit(aw_addr_ff, OFS_CTRL) && w_strb_ff[0];
    assign sweep_wr = do_wr && hit(aw_addr_ff, OFS_SWEEP) && w_strb_ff[0];
    assign irq_wr   = do_wr && hit(aw_addr_ff, OFS_IRQ) && w_strb_ff[0];

    // address and data are latched separately, in either order
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held  = w_held_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            nxt_w_held = 1'b1;
            nxt_w_data = S_AXI_WDATA_IN;
            nxt_w_strb = S_AXI_WSTRB_IN;
        end
        if (do_wr) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && S_AXI_BREADY_IN) begin
            nxt_bvalid = 1'b0;
        end
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = mapped(S_AXI_ARADDR_IN) ? RESP_OKAY : RESP_SLVERR;
            nxt_rdata  = 32'h0;
            if (hit(S_AXI_ARADDR_IN, OFS_CTRL)) begin
                nxt_rdata[CTRL_MODE_LSB +: 2] = mode_ff;
                nxt_rdata[CTRL_EXT_BIT]       = ext_ff;
                nxt_rdata[CTRL_CHAN_LSB +: 3] = sel_ff;
                nxt_rdata[CTRL_START_BIT]     = start_ff;
            end else if (hit(S_AXI_ARADDR_IN, OFS_SWEEP)) begin
                nxt_rdata[1:0] = sweep_ff;
            end else if (hit(S_AXI_ARADDR_IN, OFS_IRQ)) begin
                nxt_rdata[IRQ_FLAG_BIT]      = irq_ff;
                nxt_rdata[IRQ_BUSY_BIT]      = state_ff == ST_CONV;
                nxt_rdata[IRQ_CHAN_LSB +: 3] = chan_ff;
            end else if (is_result(S_AXI_ARADDR_IN)) begin
                nxt_rdata[7:0] = result_mem[S_AXI_ARADDR_IN[4:2]];
            end
        end else if (rvalid_ff && S_AXI_RREADY_IN) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff  <= 1'b0;
            w_data_ff  <= 32'h0;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= RESP_OKAY;
        end else begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff  <= nxt_w_held;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    assign S_AXI_BVALID_OUT = bvalid_ff;
    assign S_AXI_BRESP_OUT  = bresp_ff;
    assign S_AXI_RVALID_OUT = rvalid_ff;
    assign S_AXI_RDATA_OUT  = rdata_ff;
    assign S_AXI_RRESP_OUT  = rresp_ff;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // trigger idles high so reset never fakes a falling edge
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            trig_s1_ff <= 1'b1;
            trig_s2_ff <= 1'b1;
            trig_s3_ff <= 1'b1;
            comp_s1_ff <= 1'b0;
            comp_s2_ff <= 1'b0;
        end else begin
            trig_s1_ff <= EXT_CONV_TRIGGER_PIN_IN;
            trig_s2_ff <= trig_s1_ff;
            trig_s3_ff <= trig_s2_ff;
            comp_s1_ff <= COMP_ABOVE_IN;
            comp_s2_ff <= comp_s1_ff;
        end
    end

    assign trig_fall    = trig_s3_ff && !trig_s2_ff;
    assign sar_if.comp  = comp_s2_ff;
    assign sar_if.start = go;
    assign sar_if.abort = stop;

    // ************************************************************
    // run sequencer
    // ************************************************************
    assign is_sweep  = mode_ff == MODE_SWEEP;
    assign is_repeat = mode_ff == MODE_REPEAT;

    // a start write may switch source, mode and input in one go
    assign eff_ext   = ctrl_wr ? w_data_ff[CTRL_EXT_BIT] : ext_ff;
    assign eff_sel   = ctrl_wr ? w_data_ff[CTRL_CHAN_LSB +: 3] : sel_ff;
    assign eff_sweep = ctrl_wr ? w_data_ff[CTRL_MODE_LSB +: 2] == MODE_SWEEP
                               : is_sweep;

    always_comb begin
        nxt_state = state_ff;
        nxt_chan  = chan_ff;
        nxt_mode  = mode_ff;
        nxt_ext   = ext_ff;
        nxt_sel   = sel_ff;
        nxt_sweep = sweep_ff;
        nxt_start = start_ff;
        nxt_irq   = irq_ff;
        go        = 1'b0;
        stop      = 1'b0;
        res_we    = 1'b0;
        finish    = 1'b0;
        // an edge mid-run restarts; a second start write is ignored
        if (eff_ext) begin
            trig = trig_fall && start_ff;
        end else begin
            trig = ctrl_wr && w_data_ff[CTRL_START_BIT] &&
                   state_ff == ST_IDLE;
        end
        if (trig) begin
            go        = 1'b1;
            nxt_state = ST_CONV;
            nxt_chan  = eff_sweep ? 3'h0 : eff_sel;
        end else if (state_ff == ST_CONV && !start_ff) begin
            stop      = 1'b1;
            nxt_state = ST_IDLE;
        end else if (state_ff == ST_CONV && sar_if.done) begin
            res_we = 1'b1;
            if (is_repeat) begin
                go = 1'b1;
            end else if (is_sweep && chan_ff != sweep_last(sweep_ff)) begin
                go       = 1'b1;
                nxt_chan = chan_ff + 3'h1;
            end else begin
                finish    = 1'b1;
                nxt_state = ST_IDLE;
            end
        end
        // software write beats the hardware clear of start
        if (finish && !ext_ff) begin
            nxt_start = 1'b0;
        end
        if (ctrl_wr) begin
            nxt_mode  = acs_mode_t'(w_data_ff[CTRL_MODE_LSB +: 2]);
            nxt_ext   = w_data_ff[CTRL_EXT_BIT];
            nxt_sel   = w_data_ff[CTRL_CHAN_LSB +: 3];
            nxt_start = w_data_ff[CTRL_START_BIT];
        end
        if (sweep_wr) begin
            nxt_sweep = w_data_ff[1:0];
        end
        // hardware set beats acceptance and software clear
        if (irq_wr) begin
            nxt_irq = w_data_ff[IRQ_FLAG_BIT];
        end else if (INT_ACK_IN) begin
            nxt_irq = 1'b0;
        end
        if (finish) begin
            nxt_irq = 1'b1;
        end
        // unselected sweep inputs stay port pins
        nxt_en = is_sweep ? 8'((9'h4 << sweep_ff[1:0] * 2) - 9'h1)
                          : 8'(8'h1 << sel_ff);
    end

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_ff <= ST_IDLE;
            chan_ff  <= CHAN_RST;
            mode_ff  <= MODE_ONESHOT;
            ext_ff   <= 1'b0;
            sel_ff   <= CHAN_RST;
            sweep_ff <= SWEEP_RST;
            start_ff <= 1'b0;
            irq_ff   <= 1'b0;
            en_ff    <= 8'h0;
        end else begin
            state_ff <= nxt_state;
            chan_ff  <= nxt_chan;
            mode_ff  <= nxt_mode;
            ext_ff   <= nxt_ext;
            sel_ff   <= nxt_sel;
            sweep_ff <= nxt_sweep;
            start_ff <= nxt_start;
            irq_ff   <= nxt_irq;
            en_ff    <= nxt_en;
        end
    end

    // result n always lands in slot n
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            for (int i = 0; i < 8; i++) begin
                result_mem[i] <= RESULT_RST;
            end
        end else if (res_we) begin
            result_mem[chan_ff] <= sar_if.result;
        end
    end

    assign CONV_IRQ_OUT       = irq_ff;
    assign BUSY_OUT           = state_ff == ST_CONV;
    assign ANALOG_INPUT_N_OUT = chan_ff;
    assign ANALOG_EN_OUT      = en_ff;
    assign DAC_CODE_OUT       = sar_if.dac;

    // ************************************************************
    // checks
    // ************************************************************
    chk_result_store: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        res_we |=> result_mem[$past(chan_ff)] == $past(sar_if.result))
        else $error("result not stored for converted input");

    chk_flag_with_result: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        (sar_if.done && state_ff == ST_CONV && start_ff && !trig &&
         !is_repeat && !is_sweep) |=> irq_ff && state_ff == ST_IDLE)
        else $error("one-shot end did not raise the flag");

    chk_repeat_quiet: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        (is_repeat && !irq_ff && !irq_wr && !ctrl_wr) |=> !irq_ff)
        else $error("repeat mode raised the flag");

    chk_int_start_clear: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        (finish && !ext_ff && !ctrl_wr) |=> !start_ff)
        else $error("start bit kept after internal run");

    chk_ext_start_keep: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        (finish && ext_ff && !ctrl_wr) |=> start_ff)
        else $error("start bit lost after external run");

    chk_ext_needs_edge: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        (state_ff == ST_IDLE && eff_ext && !trig_fall) |=>
        state_ff == ST_IDLE)
        else $error("external run began without an edge");

    // a later edge may cut this run as well, so check the fresh start
    chk_abort_restart: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        (ext_ff && start_ff && trig_fall) |=>
        sar_if.busy && state_ff == ST_CONV &&
        sar_if.dac == SAR_MIDSCALE && (!is_sweep || chan_ff == 3'h0))
        else $error("falling edge did not restart the run");

    chk_sweep_order: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        (res_we && go && is_sweep && !trig) |=>
        chan_ff == $past(chan_ff) + 3'h1)
        else $error("sweep did not step up one input");

    chk_edge_pulse: assert property (
        @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
        trig_fall |=> !trig_fall)
        else $error("trigger event longer than one cycle");
endmodule
`default_nettype wire

// File: pkg/acs_pkg.sv
// Contract
// - one-shot converts selected input once, then interrupts
// - internal trigger: writing start bit begins run
// - conversion ends after 57 cycles; result stored
// - one-shot flag set with result write
// - internal trigger: completion clears start, halts
// - external trigger: falling pin edge with start set
// - external trigger: completion keeps start bit set
// - external falling edge mid-run aborts and restarts
// - repeat mode loops, never raises interrupt
// - repeat keeps start set; software clears it
// - repeat overwrites result after every conversion
// - sweep converts selected inputs ascending from zero
// - sweep stores each result when converted
// - sweep raises flag after last input
// - eight result registers, input n to n
// - sweep select chooses inputs; rest stay ports
// - flag cleared on acceptance; software writes it
// - midscale start, msb first, keep on below
package acs_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int unsigned ACS_ADDR_W     = 8;
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_SWEEP      = 8'h04;
    localparam logic [7:0]  OFS_IRQ        = 8'h08;
    localparam logic [7:0]  OFS_RESULT     = 8'h20;

    // field positions
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned CTRL_EXT_BIT   = 2;
    localparam int unsigned CTRL_CHAN_LSB  = 3;
    localparam int unsigned CTRL_START_BIT = 6;
    localparam int unsigned IRQ_FLAG_BIT   = 0;
    localparam int unsigned IRQ_BUSY_BIT   = 1;
    localparam int unsigned IRQ_CHAN_LSB   = 2;

    // reset values
    localparam logic [1:0]  MODE_RST       = 2'h0;
    localparam logic [2:0]  CHAN_RST       = 3'h0;
    localparam logic [1:0]  SWEEP_RST      = 2'h0;
    localparam logic [7:0]  SAR_MIDSCALE   = 8'h80;
    localparam logic [7:0]  RESULT_RST     = 8'h00;

    // conversion timing in converter clock cycles
    localparam int unsigned CONV_CYCLES    = 57;
    localparam int unsigned BIT_CYCLES     = 7;
    localparam logic [5:0]  CONV_LAST      = 6'(CONV_CYCLES - 1);
    localparam logic [2:0]  BIT_LAST       = 3'(BIT_CYCLES - 1);

    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef enum logic [1:0] {
        MODE_ONESHOT = 2'b00,
        MODE_REPEAT  = 2'b01,
        MODE_SWEEP   = 2'b10,
        MODE_SPARE   = 2'b11
    } acs_mode_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } acs_state_t;

endpackage

// File: pkg/acs_sar_if.sv
`timescale 1ns/1ps
`default_nettype none
// control path between the sequencer and the approximation engine
interface acs_sar_if;
    logic       start;
    logic       abort;
    logic       comp;
    logic       busy;
    logic       done;
    logic [7:0] result;
    logic [7:0] dac;
    modport ctl (output start, abort, comp, input busy, done, result, dac);
    modport sar (input start, abort, comp, output busy, done, result, dac);
endinterface
`default_nettype wire

// File: src/acs_sar.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sar
    import acs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    acs_sar_if.sar   sar
);
    logic       busy_ff,  nxt_busy;
    logic [5:0] cnt_ff,   nxt_cnt;
    logic [2:0] phase_ff, nxt_phase;
    logic [2:0] bit_ff,   nxt_bit;
    logic [7:0] sar_ff,   nxt_sar;
    logic [6:0] since_ff;

    // ************************************************************
    // approximation sequence
    // ************************************************************
    // start always wins so a restart reloads midscale at once
    always_comb begin
        nxt_busy  = busy_ff;
        nxt_cnt   = cnt_ff;
        nxt_phase = phase_ff;
        nxt_bit   = bit_ff;
        nxt_sar   = sar_ff;
        if (sar.start) begin
            nxt_busy  = 1'b1;
            nxt_cnt   = 6'h0;
            nxt_phase = 3'h0;
            nxt_bit   = 3'h7;
            nxt_sar   = SAR_MIDSCALE;
        end else if (sar.abort) begin
            nxt_busy = 1'b0;
        end else if (busy_ff) begin
            if (cnt_ff == CONV_LAST) begin
                nxt_busy = 1'b0;
            end else begin
                nxt_cnt = cnt_ff + 6'h1;
            end
            // comparator settles for a full bit period before use
            if (phase_ff == BIT_LAST && cnt_ff != CONV_LAST) begin
                nxt_phase       = 3'h0;
                nxt_sar[bit_ff] = sar.comp;
                if (bit_ff != 3'h0) begin
                    nxt_sar[bit_ff - 3'h1] = 1'b1;
                    nxt_bit = bit_ff - 3'h1;
                end
            end else begin
                nxt_phase = phase_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_ff  <= 1'b0;
            cnt_ff   <= 6'h0;
            phase_ff <= 3'h0;
            bit_ff   <= 3'h7;
            sar_ff   <= SAR_MIDSCALE;
        end else begin
            busy_ff  <= nxt_busy;
            cnt_ff   <= nxt_cnt;
            phase_ff <= nxt_phase;
            bit_ff   <= nxt_bit;
            sar_ff   <= nxt_sar;
        end
    end

    assign sar.busy   = busy_ff;
    assign sar.done   = busy_ff && cnt_ff == CONV_LAST;
    assign sar.result = sar_ff;
    assign sar.dac    = sar_ff;

    // ************************************************************
    // checks
    // ************************************************************
    // independent cycle count since the last start
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            since_ff <= 7'h0;
        end else if (sar.start) begin
            since_ff <= 7'h0;
        end else if (since_ff != 7'h7f) begin
            since_ff <= since_ff + 7'h1;
        end
    end

    chk_done_at_57: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        sar.done |-> since_ff == 7'd56)
        else $error("conversion did not end at cycle 57");

    // an abort or restart inside the first bit period is legal
    chk_sar_midscale: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        sar.start |=> sar_ff == 8'h80 ##7
        (sar_ff[6] || !busy_ff || since_ff != 7'd7))
        else $error("approximation did not start at midscale");
endmodule
`default_nettype wire

// File: sim/acs_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// analog pins plus comparator: one voltage byte per pin
module acs_pin_model (
    input  wire logic [63:0] vin_in,
    input  wire logic [2:0]  sel_in,
    input  wire logic [7:0]  dac_in,
    output logic             comp_out
);
    // no settling model: the bench changes pins mid-run only in the repeat test
    assign comp_out = dac_in < vin_in[sel_in*8 +: 8];
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rst_n, aw, wv, br, ar, rr, trig, ack, cmp, bv, rv;
    logic        awr, wr_r, arr, irq, busy;
    logic [7:0]  awa, ara, aen, dac;
    logic [31:0] wd, rd;
    logic [1:0]  bresp, rresp;
    logic [2:0]  sel;
    logic [63:0] vin;
    logic [31:0] d;
    int          err_count, checks_done, seed, i, c;
    acs_top dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .S_AXI_AWADDR_IN(awa),
        .S_AXI_AWVALID_IN(aw), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
        .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_r),
        .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
        .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(ar), .S_AXI_ARREADY_OUT(arr),
        .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
        .S_AXI_RREADY_IN(rr), .EXT_CONV_TRIGGER_PIN_IN(trig),
        .COMP_ABOVE_IN(cmp), .INT_ACK_IN(ack), .CONV_IRQ_OUT(irq),
        .BUSY_OUT(busy), .ANALOG_INPUT_N_OUT(sel), .ANALOG_EN_OUT(aen),
        .DAC_CODE_OUT(dac));
    acs_pin_model pins (.vin_in(vin), .sel_in(sel), .dac_in(dac),
        .comp_out(cmp));
    always #2 clk = ~clk;
    // ideal result: a bit stays set while its code is below the pin
    function automatic logic [7:0] sar_e(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int b = 7; b >= 0; b--) if ((r | (8'h01 << b)) < v) r |= 8'h01 << b;
        return r;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, s);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tmo();
        err_count++;
        print_verdict();
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        logic ta, tw, tb;
        @(posedge clk) {aw, wv, br, awa, wd} <= {3'b111, a, x};
        for (int n = 0; n < 50; n++) begin
            @(negedge clk) {ta, tw, tb, d[1:0]} =
                {aw & awr, wv & wr_r, bv, bresp};
            @(posedge clk) if (ta) aw <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) begin br <= 1'b0; return; end
        end
        tmo();
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ta;
        @(posedge clk) {ar, rr, ara} <= {2'b11, a};
        for (int n = 0; n < 50; n++) begin
            @(negedge clk) ta = ar & arr;
            if (rv) begin d = rd; @(posedge clk) rr <= 1'b0; return; end
            @(posedge clk) if (ta) ar <= 1'b0;
        end
        tmo();
    endtask
    // wait out one run, inputs must step up by one at a time
    task automatic run();
        logic [2:0] p;
        int n;
        for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge clk);
        p = sel;
        for (n = 0; n < 3000 && busy === 1'b1; n++) begin
            @(negedge clk) if (busy === 1'b1 && sel !== p) begin
                chk("order", p + 3'h1, sel);
                p = sel;
            end
        end
        if (n == 0 || n == 3000) tmo();
    endtask
    initial begin
        {clk, rst_n, aw, wv, br, ar, rr, ack, awa, ara, wd} = '0;
        {err_count, checks_done, trig, seed} = {32'h0, 32'h0, 1'b1, 32'd81};
        vin = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        vin <= {$random(seed), $random(seed)};
        c = $random(seed) & 7;
        wr(8'h00, 32'h40 | (c << 3));
        run();
        rdr(8'h20 + 8'(c * 4)); chk("res", sar_e(vin[c*8 +: 8]), d);
        rdr(8'h08); chk("flag", 1, d[0]);
        chk("irqo", 1, irq);
        rdr(8'h00); chk("start", 0, d[6]);
        chk("en1", 32'h1 << c, aen);
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
        rdr(8'h08); chk("ack", 0, d[0]);
        wr(8'h04, 32'h1);
        wr(8'h00, 32'h42);
        run();
        for (i = 0; i < 4; i++) begin
            rdr(8'h20 + 8'(i * 4)); chk("sw", sar_e(vin[i*8 +: 8]), d);
        end
        rdr(8'h08); chk("swf", 1, d[0]);
        chk("en4", 32'hf, aen);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h41 | (c << 3));
        repeat (130) @(posedge clk);
        vin <= ~vin; // overwrite mid-run; fresh value must land
        repeat (200) @(posedge clk);
        rdr(8'h20 + 8'(c * 4)); chk("rep", sar_e(vin[c*8 +: 8]), d);
        rdr(8'h08); chk("rpf", 0, d[0]);
        rdr(8'h00); chk("rps", 1, d[6]);
        wr(8'h00, 32'h0);
        repeat (2) @(negedge clk);
        chk("stp", 0, busy);
        wr(8'h00, 32'h44); // external, one-shot, input zero
        repeat (5) @(posedge clk);
        chk("exw", 0, busy);
        trig <= 1'b0;
        run();
        rdr(8'h00); chk("exs", 1, d[6]);
        for (i = 0; i < 2; i++) begin // second fall lands mid-run
            @(posedge clk) trig <= 1'b1;
            repeat (20) @(posedge clk);
            trig <= 1'b0;
            repeat (20) @(posedge clk);
        end
        run();
        rdr(8'h20); chk("abr", sar_e(vin[7:0]), d);
        rdr(8'h10); chk("unm", 2, rresp);
        wr(8'h10, 32'h0); chk("unw", 2, d[1:0]);
        print_verdict();
    end
endmodule
`default_nettype wire
